//--- inc/itr_pkg.sv
// ****************************************************************
// Constants and carriers of the target receiver
// ****************************************************************
package itr_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam int APB_AW = 8;
    localparam logic [7:0] REG_FLG_SET = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_OWN_ADR = 8'h0C;
    localparam logic [7:0] REG_IRQ_STS = 8'h10;
    localparam logic [7:0] REG_IRQ_MSK = 8'h14;
    localparam logic [7:0] REG_FLG_CLR = 8'h18;
    localparam logic [7:0] REG_RATE = 8'h1C;

    // ************************************************************
    // Flag register fields
    // ************************************************************
    localparam int FLG_EN = 6;
    localparam int FLG_BEG = 5;
    localparam int FLG_END = 4;
    localparam int FLG_SI = 3;
    localparam int FLG_ACK = 2;
    localparam logic [7:0] FLG_SET_MASK = 8'h74;
    localparam logic [7:0] FLG_CLR_MASK = 8'h7C;
    localparam int ADR_BC = 0;

    // ************************************************************
    // Interrupt status fields
    // ************************************************************
    localparam int IRQ_W = 4;
    localparam int IRQ_OWN = 0;
    localparam int IRQ_BC = 1;
    localparam int IRQ_DATA = 2;
    localparam int IRQ_NACK = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] FLG_RST = 8'h00;
    localparam logic [7:0] OWN_ADR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    localparam logic [15:0] RATE_RST = 16'h0000;

    // ************************************************************
    // Condition codes
    // ************************************************************
    localparam logic [7:0] ST_OWN_W = 8'h60;
    localparam logic [7:0] ST_AL_OWN_W = 8'h68;
    localparam logic [7:0] ST_BC = 8'h70;
    localparam logic [7:0] ST_AL_BC = 8'h78;
    localparam logic [7:0] ST_OWN_DACK = 8'h80;
    localparam logic [7:0] ST_OWN_DNACK = 8'h88;
    localparam logic [7:0] ST_BC_DACK = 8'h90;
    localparam logic [7:0] ST_BC_DNACK = 8'h98;
    localparam logic [7:0] ST_NONE = 8'hF8;
    localparam logic [7:0] BC_ADDR = 8'h00;

    // ************************************************************
    // Counts
    // ************************************************************
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_RST = 4'h0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } itr_bus_ev_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_AACK,
        S_DATA,
        S_DACK,
        S_HOLD
    } itr_state_t;

endpackage : itr_pkg

//--- logic/itr_pin_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Bus line synchroniser and condition detector
// ****************************************************************
module itr_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    output itr_pkg::itr_bus_ev_t ev
);
    // Stage one feeds stage two only; stage three gives the previous level
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
            s3_q <= 2'h3;
        end else if (ce) begin
            s1_q <= {scl_i, sda_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Bit 1 is the clock line, bit 0 the data line
    assign ev.scl = s2_q[1];
    assign ev.sda = s2_q[0];
    assign ev.scl_rise = s2_q[1] & ~s3_q[1];
    assign ev.scl_fall = ~s2_q[1] & s3_q[1];
    assign ev.start = s2_q[1] & s3_q[1] & ~s2_q[0] & s3_q[0];
    assign ev.stop = s2_q[1] & s3_q[1] & s2_q[0] & ~s3_q[0];

endmodule : itr_pin_sync

//--- logic/itr_target_rx.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
// ****************************************************************
// Target receiver with APB register access
// ****************************************************************
module itr_target_rx #(
    parameter int RATE_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [itr_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    input wire logic arb_lost,
    output logic irq
);

    // Refuse rate widths outside 1 to 16 bits
    if (RATE_W < 1 || RATE_W > 16) begin : g_rate_chk
        $error("RATE_W must lie between 1 and 16");
    end

    // ************************************************************
    // Registers and state
    // ************************************************************
    logic [7:0] flg_q;
    logic [7:0] flg_d;
    logic [7:0] own_adr_q;
    logic [7:0] data_q;
    logic [RATE_W-1:0] rate_q;
    logic [itr_pkg::IRQ_W-1:0] sts_q;
    logic [itr_pkg::IRQ_W-1:0] sts_d;
    logic [itr_pkg::IRQ_W-1:0] msk_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic sda_oe_d;

    itr_pkg::itr_state_t state_q;
    itr_pkg::itr_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic ack_q;
    logic ack_d;
    logic bc_q;
    logic bc_d;
    logic al_q;
    logic al_d;
    logic [7:0] code_q;
    logic [7:0] code_d;

    logic si_set;
    logic data_ld;
    logic [itr_pkg::IRQ_W-1:0] ev_bits;

    itr_pkg::itr_bus_ev_t ev;

    // ************************************************************
    // Line synchroniser
    // ************************************************************
    itr_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .ev(ev)
    );

    // ************************************************************
    // APB decode
    // ************************************************************
    wire sel_flg_set = paddr == itr_pkg::REG_FLG_SET;
    wire sel_stat = paddr == itr_pkg::REG_STAT;
    wire sel_data = paddr == itr_pkg::REG_DATA;
    wire sel_own_adr = paddr == itr_pkg::REG_OWN_ADR;
    wire sel_irq_sts = paddr == itr_pkg::REG_IRQ_STS;
    wire sel_irq_msk = paddr == itr_pkg::REG_IRQ_MSK;
    wire sel_flg_clr = paddr == itr_pkg::REG_FLG_CLR;
    wire sel_rate = paddr == itr_pkg::REG_RATE;
    wire sel_any = sel_flg_set | sel_stat | sel_data | sel_own_adr | sel_irq_sts
        | sel_irq_msk | sel_flg_clr | sel_rate;
    wire setup_ph = psel & ~penable;
    wire wr_en = psel & penable & pwrite & pready_q & sel_any;

    wire en = flg_q[itr_pkg::FLG_EN];
    wire ack_on = flg_q[itr_pkg::FLG_ACK];
    wire si = flg_q[itr_pkg::FLG_SI];

    // Status reads as idle code while no event is pending
    wire [7:0] stat_rd = si ? code_q : itr_pkg::ST_NONE;

    wire [31:0] rd_mux =
        sel_flg_set ? {24'h000000, flg_q} :
        sel_flg_clr ? {24'h000000, flg_q} :
        sel_stat ? {24'h000000, stat_rd} :
        sel_data ? {24'h000000, data_q} :
        sel_own_adr ? {24'h000000, own_adr_q} :
        sel_irq_sts ? {28'h0000000, sts_q} :
        sel_irq_msk ? {28'h0000000, msk_q} :
        sel_rate ? {{(32 - RATE_W){1'b0}}, rate_q} :
        32'h00000000;

    // ************************************************************
    // Flag register: set and clear views
    // ************************************************************
    wire [7:0] flg_set_w = (wr_en & sel_flg_set) ? (pwdata[7:0] & itr_pkg::FLG_SET_MASK)
        : 8'h00;
    wire [7:0] flg_clr_w = (wr_en & sel_flg_clr) ? (pwdata[7:0] & itr_pkg::FLG_CLR_MASK)
        : 8'h00;

    always_comb begin
        flg_d = (flg_q | flg_set_w) & ~flg_clr_w;
        // Hardware setting of the pending flag wins over a clear
        flg_d[itr_pkg::FLG_SI] = si_set | (si & ~flg_clr_w[itr_pkg::FLG_SI]);
    end

    wire [itr_pkg::IRQ_W-1:0] sts_w1c = (wr_en & sel_irq_sts) ?
        pwdata[itr_pkg::IRQ_W-1:0] : 4'h0;

    assign sts_d = ev_bits | (sts_q & ~sts_w1c);

    // ************************************************************
    // Address recognition
    // ************************************************************
    wire own_hit = (shift_q[7:1] == own_adr_q[7:1]) & ~shift_q[0];
    wire bc_hit = (shift_q == itr_pkg::BC_ADDR) & own_adr_q[itr_pkg::ADR_BC];
    wire byte_end = ev.scl_fall & (cnt_q == itr_pkg::BYTE_BITS);

    // ************************************************************
    // Receive sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        ack_d = ack_q;
        bc_d = bc_q;
        al_d = al_q;
        code_d = code_q;
        sda_oe_d = sda_oe_q;
        si_set = 1'b0;
        data_ld = 1'b0;
        ev_bits = 4'h0;
        if (!en) begin
            // Disabled: back to idle with lines released
            state_d = itr_pkg::S_IDLE;
            sda_oe_d = 1'b0;
        end else if (ev.start) begin
            // A begin condition always restarts address reception
            state_d = itr_pkg::S_ADDR;
            cnt_d = itr_pkg::CNT_RST;
            al_d = arb_lost;
            sda_oe_d = 1'b0;
        end else if (ev.stop) begin
            state_d = itr_pkg::S_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            unique case (state_q)
                itr_pkg::S_IDLE: begin
                    sda_oe_d = 1'b0;
                end
                itr_pkg::S_ADDR, itr_pkg::S_DATA: begin
                    if (state_q == itr_pkg::S_ADDR && arb_lost) begin
                        al_d = 1'b1;
                    end
                    // Bit timing follows the master's clock edges only
                    if (ev.scl_rise && cnt_q < itr_pkg::BYTE_BITS) begin
                        shift_d = {shift_q[6:0], ev.sda};
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (byte_end && state_q == itr_pkg::S_ADDR) begin
                        if (ack_on && own_hit) begin
                            bc_d = 1'b0;
                            ack_d = 1'b1;
                            sda_oe_d = 1'b1;
                            state_d = itr_pkg::S_AACK;
                        end else if (ack_on && bc_hit) begin
                            bc_d = 1'b1;
                            ack_d = 1'b1;
                            sda_oe_d = 1'b1;
                            state_d = itr_pkg::S_AACK;
                        end else begin
                            // Not for us or acknowledge off: keep watching
                            state_d = itr_pkg::S_IDLE;
                        end
                    end else if (byte_end) begin
                        ack_d = ack_on;
                        sda_oe_d = ack_on;
                        state_d = itr_pkg::S_DACK;
                    end
                end
                itr_pkg::S_AACK: begin
                    if (ev.scl_fall) begin
                        sda_oe_d = 1'b0;
                        si_set = 1'b1;
                        data_ld = 1'b1;
                        state_d = itr_pkg::S_HOLD;
                        if (bc_q) begin
                            code_d = al_q ? itr_pkg::ST_AL_BC : itr_pkg::ST_BC;
                            ev_bits[itr_pkg::IRQ_BC] = 1'b1;
                        end else begin
                            code_d = al_q ? itr_pkg::ST_AL_OWN_W : itr_pkg::ST_OWN_W;
                            ev_bits[itr_pkg::IRQ_OWN] = 1'b1;
                        end
                    end
                end
                itr_pkg::S_DACK: begin
                    if (ev.scl_fall) begin
                        sda_oe_d = 1'b0;
                        si_set = 1'b1;
                        data_ld = 1'b1;
                        state_d = itr_pkg::S_HOLD;
                        ev_bits[itr_pkg::IRQ_DATA] = 1'b1;
                        ev_bits[itr_pkg::IRQ_NACK] = ~ack_q;
                        if (ack_q) begin
                            code_d = bc_q ? itr_pkg::ST_BC_DACK : itr_pkg::ST_OWN_DACK;
                        end else begin
                            code_d = bc_q ? itr_pkg::ST_BC_DNACK : itr_pkg::ST_OWN_DNACK;
                        end
                    end
                end
                itr_pkg::S_HOLD: begin
                    // Continue only once software has cleared the flag
                    if (!si && !si_set) begin
                        cnt_d = itr_pkg::CNT_RST;
                        state_d = ack_q ? itr_pkg::S_DATA : itr_pkg::S_IDLE;
                    end
                end
                default: begin
                    state_d = itr_pkg::S_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Register storage
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flg_q <= itr_pkg::FLG_RST;
            own_adr_q <= itr_pkg::OWN_ADR_RST;
            rate_q <= RATE_W'(itr_pkg::RATE_RST);
            msk_q <= itr_pkg::IRQ_RST;
            sts_q <= itr_pkg::IRQ_RST;
        end else if (ce) begin
            flg_q <= flg_d;
            sts_q <= sts_d;
            if (wr_en && sel_own_adr) begin
                own_adr_q <= pwdata[7:0];
            end
            if (wr_en && sel_rate) begin
                rate_q <= pwdata[RATE_W-1:0];
            end
            if (wr_en && sel_irq_msk) begin
                msk_q <= pwdata[itr_pkg::IRQ_W-1:0];
            end
        end
    end

    // Received byte wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= itr_pkg::DATA_RST;
        end else if (ce) begin
            if (data_ld) begin
                data_q <= shift_q;
            end else if (wr_en && sel_data) begin
                data_q <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // APB answer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (ce) begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph & ~sel_any;
            if (setup_ph) begin
                prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    // ************************************************************
    // Sequencer state and line drivers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= itr_pkg::S_IDLE;
            cnt_q <= itr_pkg::CNT_RST;
            shift_q <= 8'h00;
            ack_q <= 1'b0;
            bc_q <= 1'b0;
            al_q <= 1'b0;
            code_q <= itr_pkg::ST_NONE;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            ack_q <= ack_d;
            bc_q <= bc_d;
            al_q <= al_d;
            code_q <= code_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= state_d == itr_pkg::S_HOLD;
            irq_q <= |(sts_d & msk_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    // Open-drain lines only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

endmodule : itr_target_rx

//--- sim/itr_master_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Bus master transmitter, 32 ns bit period, lines idle high
// ****************************************************************
module itr_master_model (
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_m,
    output logic sda_m,
    output logic hung
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
        hung = 1'b0;
    end

    // Waits out a held clock, bounded
    task automatic wait_high();
        int n;
        n = 0;
        while (scl_w !== 1'b1 && n < 2000) begin
            #4;
            n++;
        end
        if (n >= 2000) hung = 1'b1;
    endtask : wait_high

    task automatic clk_bit(input logic b, output logic r);
        #4 sda_m = b;
        #20 scl_m = 1'b1;
        wait_high();
        #4 r = sda_w;
        #4 scl_m = 1'b0;
    endtask : clk_bit

    task automatic start_cond();
        #16 sda_m = 1'b0;
        #16 scl_m = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #4 sda_m = 1'b0;
        #20 scl_m = 1'b1;
        wait_high();
        #16 sda_m = 1'b1;
        #16;
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
        clk_bit(1'b1, r);
        acked = !r;
    endtask : send_byte
endmodule : itr_master_model

//--- sim/itr_target_rx_properties.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checks of the target receiver
// ****************************************************************
module itr_target_rx_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [itr_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic irq
);
    wire any_wr = psel && penable && pready && pwrite;
    wire clr_wr = any_wr && (paddr == itr_pkg::REG_FLG_CLR)
        && (pwdata[itr_pkg::FLG_SI] || pwdata[itr_pkg::FLG_EN]);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Acknowledge ends on the ninth falling edge, clock held from then on
    sequence s_ack_end;
        ##[1:40] ($fell(sda_oe) && scl_oe);
    endsequence

    AST_SETUP_ANSWER: assert property (psel && !penable && ce |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_QUAL: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("bad error answer");
    AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    AST_ACK_IN_LOW: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("ack began with clock high");
    AST_ACK_WINDOW: assert property ($rose(sda_oe) |-> s_ack_end)
        else $error("ack not closed by stretch");
    AST_STRETCH_IN_LOW: assert property ($rose(scl_oe) |-> !scl_i)
        else $error("stretch began with clock high");
    AST_STRETCH_RELEASE: assert property ($fell(scl_oe) |->
        $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3))
        else $error("stretch released without clear");
    AST_STRETCH_HOLD: assert property (scl_oe && !clr_wr && !$past(clr_wr) |=> scl_oe)
        else $error("stretch dropped early");
    AST_IRQ_FALL_CAUSE: assert property ($fell(irq) |->
        $past(any_wr) || $past(any_wr, 2) || $past(any_wr, 3))
        else $error("irq dropped without write");
endmodule : itr_target_rx_properties

bind itr_target_rx itr_target_rx_properties u_props (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq(irq));

//--- sim/tb_i2c_target_receiver.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench of the target receiver
// ****************************************************************
module tb_i2c_target_receiver;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, arb_lost;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq;
    logic scl_m, sda_m, hung, err, ack;
    int num_errors = 0;
    int checks_done = 0;
    // Open-drain lines with pull-ups
    wire scl_w = scl_m && !(scl_oe && !scl_o);
    wire sda_w = sda_m && !(sda_oe && !sda_o);

    always #2 pclk = ~pclk;

    itr_target_rx uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
        .sda_i(sda_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
        .sda_oe(sda_oe), .arb_lost(arb_lost), .irq(irq));
    itr_master_model u_mst (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
        .sda_m(sda_m), .hung(hung));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Access phase lasts until pready is seen high at a rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            close_out();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd

    task automatic irq_is(input logic exp);
        repeat (2) @(negedge pclk);
        check(irq, exp);
    endtask : irq_is

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 1000) begin
            num_errors++;
            close_out();
        end
    endtask : wait_irq

    // Checks the code with the clock held, then clears events and flags
    task automatic service(input logic [7:0] code, input logic [7:0] clr);
        wait_irq();
        check(scl_oe, 1'b1);
        rd(itr_pkg::REG_STAT, {24'h0, code});
        wr(itr_pkg::REG_IRQ_STS, 32'h0000000F);
        wr(itr_pkg::REG_FLG_CLR, {24'h0, clr});
    endtask : service

    task automatic xfer(input logic st, input logic [7:0] b, input logic exp_ack);
        if (st) u_mst.start_cond();
        u_mst.send_byte(b, ack);
        check(ack, exp_ack);
    endtask : xfer

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        arb_lost = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(itr_pkg::REG_FLG_SET, 32'h0);
        rd(itr_pkg::REG_STAT, 32'hF8);
        rd(itr_pkg::REG_OWN_ADR, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check(err, 1'b1);
        wr(itr_pkg::REG_OWN_ADR, 32'h54);
        rd(itr_pkg::REG_OWN_ADR, 32'h54);
        wr(itr_pkg::REG_RATE, 32'hFFFF);
        wr(itr_pkg::REG_IRQ_MSK, 32'hF);
        wr(itr_pkg::REG_FLG_SET, 32'h44);
        rd(itr_pkg::REG_FLG_SET, 32'h44);
        xfer(1'b1, 8'h54, 1'b1);
        wait_irq();
        rd(itr_pkg::REG_IRQ_STS, 32'h1);
        wr(itr_pkg::REG_IRQ_MSK, 32'h0);
        irq_is(1'b0);
        wr(itr_pkg::REG_IRQ_MSK, 32'hF);
        irq_is(1'b1);
        service(itr_pkg::ST_OWN_W, 8'h08);
        irq_is(1'b0);
        xfer(1'b0, 8'hA5, 1'b1);
        service(itr_pkg::ST_OWN_DACK, 8'h0C);
        rd(itr_pkg::REG_DATA, 32'hA5);
        xfer(1'b0, 8'h3C, 1'b0);
        service(itr_pkg::ST_OWN_DNACK, 8'h08);
        u_mst.stop_cond();
        xfer(1'b1, 8'h54, 1'b0);
        u_mst.stop_cond();
        wr(itr_pkg::REG_FLG_SET, 32'h04);
        xfer(1'b1, 8'h54, 1'b1);
        service(itr_pkg::ST_OWN_W, 8'h08);
        u_mst.stop_cond();
        xfer(1'b1, 8'h55, 1'b0);
        u_mst.stop_cond();
        xfer(1'b1, 8'h56, 1'b0);
        u_mst.stop_cond();
        xfer(1'b1, 8'h00, 1'b0);
        u_mst.stop_cond();
        wr(itr_pkg::REG_OWN_ADR, 32'h55);
        xfer(1'b1, 8'h00, 1'b1);
        service(itr_pkg::ST_BC, 8'h08);
        u_mst.stop_cond();
        @(posedge pclk);
        arb_lost <= 1'b1;
        xfer(1'b1, 8'h54, 1'b1);
        service(itr_pkg::ST_AL_OWN_W, 8'h08);
        arb_lost <= 1'b0;
        xfer(1'b0, 8'h5A, 1'b1);
        service(itr_pkg::ST_OWN_DACK, 8'h08);
        u_mst.stop_cond();
        @(posedge pclk);
        arb_lost <= 1'b1;
        xfer(1'b1, 8'h00, 1'b1);
        service(itr_pkg::ST_AL_BC, 8'h08);
        arb_lost <= 1'b0;
        u_mst.stop_cond();
        check(hung, 1'b0);
        close_out();
    end
endmodule : tb_i2c_target_receiver
